// File: verilog/ppo_pkg.sv
/*
  Shared constants and carriers for the port pin override block:
  register map, field positions, converter select codes, bus structs.
  Assumes an AXI4-Lite master with 32-bit data and 8-bit byte addresses.
*/
package ppo_pkg;

  localparam int unsigned NPIN   = 2;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] ADDR_DATA = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_DIR  = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_PIN  = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h0C;

  // Control register fields
  localparam int unsigned CTRL_PUD_BIT = 0;
  localparam int unsigned CTRL_DID_LSB = 1;
  localparam int unsigned CTRL_W       = 1 + NPIN;

  localparam logic [NPIN-1:0]   PIN_RST  = 2'h0;
  localparam logic [CTRL_W-1:0] CTRL_RST = 3'h0;

  // Voltage converter channel select that grabs each pin
  localparam int unsigned VSEL_W = 3;
  localparam logic [VSEL_W-1:0] VSEL_CODE [NPIN] = '{3'h2, 3'h1};

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [0:0] {
    WR_IDLE = 1'b0,
    WR_RESP = 1'b1
  } ppo_wr_state_t;

  typedef struct packed {
    logic pullup_ovr_en;
    logic pullup_ovr_val;
    logic dir_ovr_en;
    logic dir_ovr_val;
    logic outval_ovr_en;
    logic outval_ovr_val;
    logic outval_toggle_ovr;
    logic din_enable_ovr_en;
    logic din_enable_ovr_val;
  } ppo_ovr_t;

  typedef struct packed {
    logic [ADDR_W-1:0] awaddr;
    logic              awvalid;
    logic [DATA_W-1:0] wdata;
    logic [3:0]        wstrb;
    logic              wvalid;
    logic              bready;
    logic [ADDR_W-1:0] araddr;
    logic              arvalid;
    logic              rready;
  } ppo_axil_req_t;

  typedef struct packed {
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0]        rresp;
  } ppo_axil_rsp_t;

endpackage

// File: verilog/ppo_port_pin.sv
/*
  Two-pin general-purpose port with alternate-function overrides,
  sleep input clamp, pin-change detection and an AXI4-Lite register file.
  Assumes pads resolve the drive/pull-up controls; analog paths are bonded
  straight to the pad outside this logic, gated by the analog select.
*/
// Design decisions made here: the AXI4-Lite interface to the registers and the address map.
// Operation
// - Sleep clamps digital input before schmitt trigger
// - Enabled external interrupt pins escape sleep clamp
// - Clamp release on high pin flags change
// - Reset disables every pull-up
// - Pull-up on for dir,data,pud equal 010
// - Pull-up override value decides when enabled
// - Direction bit drives output enable by default
// - Direction override value decides when enabled
// - Driven level from override or data bit
// - Value override presents override level
// - Toggle override inverts output data bit
// - Input enable follows sleep state by default
// - Input enable override value decides when enabled
// - Alternate functions get unsynchronised schmitt output
// - Analog path goes straight to pad
// - Low pins serve converter, ground, pin-change
// - Strobes per port; clamp, pud shared
// - Plain pin: output or pulled-up input
// - Writing one to input bit toggles data
// - Pin passes latch then rising-edge register
`timescale 1ns/1ps
module ppo_port_pin
  import ppo_pkg::*;
(
  input  wire logic                ref_clk_i,
  input  wire logic                rst_n_i,
  input  wire ppo_axil_req_t       axil_req_i,
  output ppo_axil_rsp_t            axil_rsp_o,
  input  wire ppo_ovr_t [NPIN-1:0] ovr_i,
  input  wire logic                sleep_i,
  input  wire logic [NPIN-1:0]     ext_irq_en_i,
  input  wire logic [VSEL_W-1:0]   vconv_sel_i,
  input  wire logic [NPIN-1:0]     pad_in_i,
  output logic [NPIN-1:0]          pad_out_o,
  output logic [NPIN-1:0]          pad_oe_o,
  output logic [NPIN-1:0]          pad_pullup_o,
  output logic [NPIN-1:0]          alt_digital_in_o,
  output logic [NPIN-1:0]          alt_analog_io_sel_o,
  output logic [NPIN-1:0]          pin_change_irq_o
);

  // Register file and bus state
  ppo_wr_state_t     wst_r,      wst_nxt;
  logic              aw_held_r,  aw_held_nxt;
  logic [ADDR_W-1:0] awaddr_r,   awaddr_nxt;
  logic              w_held_r,   w_held_nxt;
  logic [DATA_W-1:0] wdata_r,    wdata_nxt;
  logic              wstrb0_r,   wstrb0_nxt;
  logic              awready_r,  awready_nxt;
  logic              wready_r,   wready_nxt;
  logic              bvalid_r,   bvalid_nxt;
  logic [1:0]        bresp_r,    bresp_nxt;
  logic              arready_r,  arready_nxt;
  logic              rvalid_r,   rvalid_nxt;
  logic [DATA_W-1:0] rdata_r,    rdata_nxt;
  logic [1:0]        rresp_r,    rresp_nxt;
  logic [NPIN-1:0]   data_r,     data_nxt;
  logic [NPIN-1:0]   dir_r,      dir_nxt;
  logic [CTRL_W-1:0] ctrl_r,     ctrl_nxt;

  // Input path
  logic [NPIN-1:0]   meta_r;
  logic [NPIN-1:0]   pin_in_r,   pin_in_nxt;
  logic [NPIN-1:0]   din_prev_r, din_prev_nxt;
  logic [NPIN-1:0]   irq_r,      irq_nxt;

  // Pad controls
  logic [NPIN-1:0]   oe_r,       oe_nxt;
  logic [NPIN-1:0]   out_r,      out_nxt;
  logic [NPIN-1:0]   pu_r,       pu_nxt;
  logic [NPIN-1:0]   asel_r,     asel_nxt;
  logic [NPIN-1:0]   din_en;
  logic [NPIN-1:0]   din_clamped;

  logic              global_pullup_off;
  logic [NPIN-1:0]   did;

  assign global_pullup_off = ctrl_r[CTRL_PUD_BIT];
  assign did = ctrl_r[CTRL_DID_LSB +: NPIN];

  // Pin control: overrides from peripherals merged with converter grab
  always_comb begin
    logic [NPIN-1:0] data_eff;
    logic [NPIN-1:0] dd_en;
    logic [NPIN-1:0] dd_val;
    logic [NPIN-1:0] pv_en;
    logic [NPIN-1:0] pv_val;
    logic [NPIN-1:0] die_en;
    logic [NPIN-1:0] die_val;
    logic [NPIN-1:0] grab;
    data_eff = '0;
    dd_en    = '0;
    dd_val   = '0;
    pv_en    = '0;
    pv_val   = '0;
    die_en   = '0;
    die_val  = '0;
    grab     = '0;
    for (int i = 0; i < NPIN; i++) begin
      grab[i]     = (vconv_sel_i == VSEL_CODE[i]);
      data_eff[i] = data_r[i] ^ ovr_i[i].outval_toggle_ovr;
      // Converter grab drives low as signal ground
      dd_en[i]  = ovr_i[i].dir_ovr_en | grab[i];
      dd_val[i] = ovr_i[i].dir_ovr_en ? ovr_i[i].dir_ovr_val : 1'b1;
      pv_en[i]  = ovr_i[i].outval_ovr_en | grab[i];
      pv_val[i] = ovr_i[i].outval_ovr_en & ovr_i[i].outval_ovr_val;
      // Digital disable bit shuts the input off for analog use
      die_en[i]  = ovr_i[i].din_enable_ovr_en | did[i];
      die_val[i] = ovr_i[i].din_enable_ovr_en ?
                   ovr_i[i].din_enable_ovr_val : 1'b0;
      if (ovr_i[i].pullup_ovr_en) begin
        pu_nxt[i] = ovr_i[i].pullup_ovr_val;
      end else begin
        pu_nxt[i] = ~dir_r[i] & data_eff[i] & ~global_pullup_off;
      end
      oe_nxt[i]  = dd_en[i] ? dd_val[i] : dir_r[i];
      out_nxt[i] = pv_en[i] ? pv_val[i] : data_eff[i];
      if (die_en[i]) begin
        din_en[i] = die_val[i];
      end else begin
        din_en[i] = ~(sleep_i & ~ext_irq_en_i[i]);
      end
      asel_nxt[i] = grab[i];
    end
  end

  // Clamp to ground ahead of the schmitt trigger
  assign din_clamped = pad_in_i & din_en;
  // Handed on raw; each peripheral brings its own synchroniser
  assign alt_digital_in_o = din_clamped;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      oe_r   <= PIN_RST;
      out_r  <= PIN_RST;
      pu_r   <= PIN_RST;
      asel_r <= PIN_RST;
    end else begin
      oe_r   <= oe_nxt;
      out_r  <= out_nxt;
      pu_r   <= pu_nxt;
      asel_r <= asel_nxt;
    end
  end

  // Latch stage: closes on the falling edge, like the transparent-high
  // latch, so the value settles for half a period before the register
  always_ff @(negedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= PIN_RST;
    end else begin
      meta_r <= din_clamped;
    end
  end

  always_comb begin
    pin_in_nxt   = meta_r;
    din_prev_nxt = pin_in_r;
    // A high pin released from the clamp reads as a change on wake
    irq_nxt      = pin_in_r ^ din_prev_r;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_in_r   <= PIN_RST;
      din_prev_r <= PIN_RST;
      irq_r      <= PIN_RST;
    end else begin
      pin_in_r   <= pin_in_nxt;
      din_prev_r <= din_prev_nxt;
      irq_r      <= irq_nxt;
    end
  end

  // Write channel: address and data taken in either order
  always_comb begin
    logic do_wr;
    do_wr       = 1'b0;
    wst_nxt     = wst_r;
    aw_held_nxt = aw_held_r;
    awaddr_nxt  = awaddr_r;
    w_held_nxt  = w_held_r;
    wdata_nxt   = wdata_r;
    wstrb0_nxt  = wstrb0_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    data_nxt    = data_r;
    dir_nxt     = dir_r;
    ctrl_nxt    = ctrl_r;
    if (axil_req_i.awvalid && awready_r) begin
      aw_held_nxt = 1'b1;
      awaddr_nxt  = axil_req_i.awaddr;
    end
    if (axil_req_i.wvalid && wready_r) begin
      w_held_nxt = 1'b1;
      wdata_nxt  = axil_req_i.wdata;
      wstrb0_nxt = axil_req_i.wstrb[0];
    end
    case (wst_r)
      WR_IDLE: begin
        if (aw_held_r && w_held_r) begin
          do_wr       = 1'b1;
          aw_held_nxt = 1'b0;
          w_held_nxt  = 1'b0;
          bvalid_nxt  = 1'b1;
          wst_nxt     = WR_RESP;
        end
      end
      WR_RESP: begin
        if (axil_req_i.bready) begin
          bvalid_nxt = 1'b0;
          wst_nxt    = WR_IDLE;
        end
      end
      default: begin
        wst_nxt = WR_IDLE;
      end
    endcase
    if (do_wr) begin
      bresp_nxt = RESP_OKAY;
      case (awaddr_r)
        ADDR_DATA: if (wstrb0_r) data_nxt = wdata_r[NPIN-1:0];
        ADDR_DIR:  if (wstrb0_r) dir_nxt  = wdata_r[NPIN-1:0];
        ADDR_PIN:  if (wstrb0_r) data_nxt = data_r ^ wdata_r[NPIN-1:0];
        ADDR_CTRL: if (wstrb0_r) ctrl_nxt = wdata_r[CTRL_W-1:0];
        default:   bresp_nxt = RESP_SLVERR;
      endcase
    end
    awready_nxt = (wst_nxt == WR_IDLE) && !aw_held_nxt;
    wready_nxt  = (wst_nxt == WR_IDLE) && !w_held_nxt;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wst_r     <= WR_IDLE;
      aw_held_r <= 1'b0;
      awaddr_r  <= '0;
      w_held_r  <= 1'b0;
      wdata_r   <= '0;
      wstrb0_r  <= 1'b0;
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
      data_r    <= PIN_RST;
      dir_r     <= PIN_RST;
      ctrl_r    <= CTRL_RST;
    end else begin
      wst_r     <= wst_nxt;
      aw_held_r <= aw_held_nxt;
      awaddr_r  <= awaddr_nxt;
      w_held_r  <= w_held_nxt;
      wdata_r   <= wdata_nxt;
      wstrb0_r  <= wstrb0_nxt;
      awready_r <= awready_nxt;
      wready_r  <= wready_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      data_r    <= data_nxt;
      dir_r     <= dir_nxt;
      ctrl_r    <= ctrl_nxt;
    end
  end

  // Read channel: one outstanding read, data one cycle after address
  always_comb begin
    rvalid_nxt = rvalid_r;
    rdata_nxt  = rdata_r;
    rresp_nxt  = rresp_r;
    if (rvalid_r && axil_req_i.rready) begin
      rvalid_nxt = 1'b0;
    end
    if (axil_req_i.arvalid && arready_r) begin
      rvalid_nxt = 1'b1;
      rdata_nxt  = '0;
      rresp_nxt  = RESP_OKAY;
      case (axil_req_i.araddr)
        ADDR_DATA: rdata_nxt[NPIN-1:0]   = data_r;
        ADDR_DIR:  rdata_nxt[NPIN-1:0]   = dir_r;
        ADDR_PIN:  rdata_nxt[NPIN-1:0]   = pin_in_r;
        ADDR_CTRL: rdata_nxt[CTRL_W-1:0] = ctrl_r;
        default:   rresp_nxt = RESP_SLVERR;
      endcase
    end
    arready_nxt = !rvalid_nxt;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= '0;
      rresp_r   <= RESP_OKAY;
    end else begin
      arready_r <= arready_nxt;
      rvalid_r  <= rvalid_nxt;
      rdata_r   <= rdata_nxt;
      rresp_r   <= rresp_nxt;
    end
  end

  always_comb begin
    axil_rsp_o.awready = awready_r;
    axil_rsp_o.wready  = wready_r;
    axil_rsp_o.bvalid  = bvalid_r;
    axil_rsp_o.bresp   = bresp_r;
    axil_rsp_o.arready = arready_r;
    axil_rsp_o.rvalid  = rvalid_r;
    axil_rsp_o.rdata   = rdata_r;
    axil_rsp_o.rresp   = rresp_r;
  end

  assign pad_out_o           = out_r;
  assign pad_oe_o            = oe_r;
  assign pad_pullup_o        = pu_r;
  assign alt_analog_io_sel_o = asel_r;
  assign pin_change_irq_o    = irq_r;

endmodule // ppo_port_pin

// File: verif/ppo_pad_model.sv
/* Pad model for both pins: drive, pull-up or an outside source.
   Assumes no pull-down; an undriven pad without pull-up flips every cycle. */
`timescale 1ns/1ps
module ppo_pad_model
  import ppo_pkg::*;
(
  input  wire logic            ref_clk_i,
  input  wire logic [NPIN-1:0] pad_out_i,
  input  wire logic [NPIN-1:0] pad_oe_i,
  input  wire logic [NPIN-1:0] pad_pullup_i,
  input  wire logic [NPIN-1:0] ext_en_i,
  input  wire logic [NPIN-1:0] ext_val_i,
  output logic [NPIN-1:0]      pad_in_o
);
  logic [NPIN-1:0] last_r;
  always_ff @(posedge ref_clk_i) begin
    last_r <= pad_in_o;
  end
  // Floating pad never keeps its last level
  assign pad_in_o = pad_oe_i & pad_out_i | ~pad_oe_i &
    (ext_en_i & ext_val_i | ~ext_en_i & (pad_pullup_i | ~last_r));
endmodule // ppo_pad_model

// File: verif/ppo_port_pin_props.sv
/* Port assertions for the pin override block.
   Assumes one clock and an asynchronous active-low reset. */
`timescale 1ns/1ps
module ppo_port_pin_props
  import ppo_pkg::*;
(
  input wire logic                ref_clk_i,
  input wire logic                rst_n_i,
  input wire ppo_axil_req_t       axil_req_i,
  input wire ppo_axil_rsp_t       axil_rsp_o,
  input wire ppo_ovr_t [NPIN-1:0] ovr_i,
  input wire logic                sleep_i,
  input wire logic [NPIN-1:0]     ext_irq_en_i,
  input wire logic [VSEL_W-1:0]   vconv_sel_i,
  input wire logic [NPIN-1:0]     pad_in_i,
  input wire logic [NPIN-1:0]     pad_out_o,
  input wire logic [NPIN-1:0]     pad_oe_o,
  input wire logic [NPIN-1:0]     pad_pullup_o,
  input wire logic [NPIN-1:0]     alt_digital_in_o,
  input wire logic [NPIN-1:0]     alt_analog_io_sel_o,
  input wire logic [NPIN-1:0]     pin_change_irq_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  property p_rst_off;
    disable iff (1'b0) !rst_n_i |-> pad_pullup_o == 2'h0 && pad_oe_o == 2'h0;
  endproperty
  a_rst_off: assert property (p_rst_off) else $error("pad on in reset");
  property p_pu_ovr;
    ovr_i[1].pullup_ovr_en |=> pad_pullup_o[1] == $past(ovr_i[1].pullup_ovr_val);
  endproperty
  a_pu_ovr: assert property (p_pu_ovr) else $error("pull-up ovr");
  property p_dir_ovr;
    ovr_i[1].dir_ovr_en |=> pad_oe_o[1] == $past(ovr_i[1].dir_ovr_val);
  endproperty
  a_dir_ovr: assert property (p_dir_ovr) else $error("dir ovr");
  property p_val_ovr;
    ovr_i[1].dir_ovr_en && ovr_i[1].dir_ovr_val && ovr_i[1].outval_ovr_en
      |=> pad_out_o[1] == $past(ovr_i[1].outval_ovr_val);
  endproperty
  a_val_ovr: assert property (p_val_ovr) else $error("value ovr");
  property p_clamp;
    (sleep_i && !ext_irq_en_i[0] && !ovr_i[0].din_enable_ovr_en) [*2]
      |-> !alt_digital_in_o[0];
  endproperty
  a_clamp: assert property (p_clamp) else $error("no clamp");
  sequence s_pad_moved;
    !sleep_i && !ovr_i[0].din_enable_ovr_en && $changed(pad_in_i[0]);
  endsequence
  property p_chg;
    s_pad_moved |-> ##[1:3] pin_change_irq_o[0];
  endproperty
  a_chg: assert property (p_chg) else $error("no change pulse");
  property p_grab;
    vconv_sel_i == VSEL_CODE[0] && !ovr_i[0].dir_ovr_en &&
      !ovr_i[0].outval_ovr_en |=> pad_oe_o[0] && !pad_out_o[0] &&
      alt_analog_io_sel_o[0];
  endproperty
  a_grab: assert property (p_grab) else $error("grab");
  sequence s_wr_taken;
    axil_req_i.awvalid && axil_rsp_o.awready &&
      axil_req_i.wvalid && axil_rsp_o.wready;
  endsequence
  property p_wr_resp;
    s_wr_taken |-> ##2 axil_rsp_o.bvalid;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("late write resp");
endmodule // ppo_port_pin_props

bind ppo_port_pin ppo_port_pin_props u_props (
  .ref_clk_i           (ref_clk_i),
  .rst_n_i             (rst_n_i),
  .axil_req_i          (axil_req_i),
  .axil_rsp_o          (axil_rsp_o),
  .ovr_i               (ovr_i),
  .sleep_i             (sleep_i),
  .ext_irq_en_i        (ext_irq_en_i),
  .vconv_sel_i         (vconv_sel_i),
  .pad_in_i            (pad_in_i),
  .pad_out_o           (pad_out_o),
  .pad_oe_o            (pad_oe_o),
  .pad_pullup_o        (pad_pullup_o),
  .alt_digital_in_o    (alt_digital_in_o),
  .alt_analog_io_sel_o (alt_analog_io_sel_o),
  .pin_change_irq_o    (pin_change_irq_o)
);

// File: verif/tb_top.sv
/* Self-checking bench for the pin override block with a pad model.
   Assumes the register map and bus timing of the block's package. */
`timescale 1ns/1ps
module tb_top
  import ppo_pkg::*;
;
  logic                clk = 1'b0;
  // Driven at time zero by non-blocking assignment so the reset edge is seen
  logic                rst_n;
  ppo_axil_req_t       req = '0;
  ppo_axil_rsp_t       rsp;
  ppo_ovr_t [NPIN-1:0] ovr = '0;
  logic                sleep = 1'b0;
  logic                hit;
  logic [NPIN-1:0]     irq_en = 2'h0, ext_en = 2'h3, ext_val = 2'h0;
  logic [NPIN-1:0]     pad_in, out, oe, pu, adi, asel, pci;
  logic [VSEL_W-1:0]   vsel = 3'h0;
  logic [31:0]         rdat;
  logic [1:0]          resp;
  int                  fail_count = 0, samples_checked = 0;
  always #2.5 clk = ~clk;
  ppo_port_pin uut (.ref_clk_i(clk), .rst_n_i(rst_n), .axil_req_i(req),
    .axil_rsp_o(rsp), .ovr_i(ovr), .sleep_i(sleep), .ext_irq_en_i(irq_en),
    .vconv_sel_i(vsel), .pad_in_i(pad_in), .pad_out_o(out), .pad_oe_o(oe),
    .pad_pullup_o(pu), .alt_digital_in_o(adi), .alt_analog_io_sel_o(asel),
    .pin_change_irq_o(pci));
  ppo_pad_model u_pad (.ref_clk_i(clk), .pad_out_i(out), .pad_oe_i(oe),
    .pad_pullup_i(pu), .ext_en_i(ext_en), .ext_val_i(ext_val),
    .pad_in_o(pad_in));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  // Ready is registered, so the falling-edge copy is what the edge sees
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    @(posedge clk);
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    do begin
      @(negedge clk);
      aw = rsp.awready;
      w = rsp.wready;
      b = rsp.bvalid;
      resp = rsp.bresp;
      @(posedge clk);
      if (aw) req.awvalid <= 1'b0;
      if (w) req.wvalid <= 1'b0;
    end while (!b);
    req.bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    logic ar, v;
    @(posedge clk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do begin
      @(negedge clk);
      ar = rsp.arready;
      v = rsp.rvalid;
      rdat = rsp.rdata;
      resp = rsp.rresp;
      @(posedge clk);
      if (ar) req.arvalid <= 1'b0;
    end while (!v);
    req.rready <= 1'b0;
  endtask
  task automatic t_plain;
    logic [2:0] c;
    for (int i = 0; i < 8; i++) begin
      c = i[2:0];
      wr(ADDR_DIR, {31'h0, c[2]});
      wr(ADDR_DATA, {31'h0, c[1]});
      wr(ADDR_CTRL, {31'h0, c[0]});
      tick(2);
      chk(oe[0], c[2]);
      chk(pu[0], c == 3'h2);
      if (c[2]) chk(out[0], c[1]);
    end
    $display("plain pin done");
  endtask
  task automatic t_rst;
    wr(ADDR_DIR, 32'h0);
    wr(ADDR_DATA, 32'h1);
    wr(ADDR_CTRL, 32'h0);
    tick(2);
    chk(pu[0], 1'b1);
    // Release pin 0 so only the pull-up holds it
    @(posedge clk);
    ext_en <= 2'h2;
    tick(2);
    rd(ADDR_PIN);
    chk(rdat, 32'h1);
    @(posedge clk);
    rst_n <= 1'b0;
    tick(2);
    chk({pu, oe}, 4'h0);
    // Drive the pad again before release, so no change shows after it
    @(posedge clk);
    ext_en <= 2'h3;
    @(posedge clk);
    rst_n <= 1'b1;
    $display("reset done");
  endtask
  task automatic t_ovr;
    logic [1:0] v;
    for (int i = 0; i < 4; i++) begin
      v = i[1:0];
      @(posedge clk);
      ovr[1] <= {1'b1, v[0], 1'b1, v[1], 1'b1, v[0], 3'h0};
      tick(2);
      chk(pu[1], v[0]);
      chk(oe[1], v[1]);
      if (v[1]) chk(out[1], v[0]);
    end
    @(posedge clk);
    ovr[1] <= 9'h064;
    tick(2);
    chk(out[1], 1'b1);
    @(posedge clk);
    ovr[1] <= 9'h000;
    $display("overrides done");
  endtask
  task automatic t_pin;
    wr(ADDR_PIN, 32'h1);
    chk(resp, RESP_OKAY);
    rd(ADDR_DATA);
    chk(rdat, 32'h1);
    @(posedge clk);
    ext_val <= 2'h1;
    tick(2);
    rd(ADDR_PIN);
    chk(rdat, 32'h1);
    rd(8'h10);
    chk(rdat, 32'h0);
    chk(resp, RESP_SLVERR);
    wr(8'h10, 32'h3);
    chk(resp, RESP_SLVERR);
    rd(ADDR_DATA);
    chk(rdat, 32'h1);
    $display("pin register done");
  endtask
  task automatic t_sleep;
    // Digital disable bit of pin 0 shuts its input for analog use
    wr(ADDR_CTRL, 32'h2);
    @(negedge clk);
    chk(adi[0], 1'b0);
    wr(ADDR_CTRL, 32'h0);
    @(negedge clk);
    chk(adi[0], 1'b1);
    @(posedge clk);
    sleep <= 1'b1;
    tick(2);
    chk(adi[0], 1'b0);
    @(posedge clk);
    irq_en <= 2'h1;
    tick(2);
    chk(adi[0], 1'b1);
    @(posedge clk);
    irq_en <= 2'h0;
    ovr[0] <= 9'h003;
    tick(2);
    chk(adi[0], 1'b1);
    @(posedge clk);
    ovr[0] <= 9'h000;
    tick(2);
    @(posedge clk);
    sleep <= 1'b0;
    hit = 1'b0;
    repeat (6) begin
      @(negedge clk);
      hit = hit | pci[0];
    end
    chk(hit, 1'b1);
    chk(adi[0], 1'b1);
    @(posedge clk);
    ext_val <= 2'h0;
    @(negedge clk);
    chk(adi[0], 1'b0);
    $display("sleep done");
  endtask
  task automatic t_grab;
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      vsel <= VSEL_CODE[i];
      tick(2);
      chk({asel[i], oe[i], out[i]}, 3'h6);
    end
    @(posedge clk);
    vsel <= 3'h0;
    $display("converter grab done");
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_plain;
    t_rst;
    t_ovr;
    t_pin;
    t_sleep;
    t_grab;
    end_of_test;
  end
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    end_of_test;
  end
endmodule // tb_top
